// >>> lvdet_pkg.sv
// Constants, register map and timing counts of the low-voltage detector
// controller. Assumes a 100 MHz pclk and 32-bit APB data.
// Function
// - Control register bits 7 and 6 always read as zero.
// - Bit 5 is a read-only flag: 1 low voltage seen, 0 none.
// - Bit 4 switches the detector circuits on (1) or off (0).
// - Bit 3 switches the bandgap buffer on (1) or off (0).
// - Threshold code 0 picks the 1.04V pin check, 1 to 7 pick 2.2V..4.0V.
// - Code 0 compares the sense pin, other codes compare the supply.
// - Flag is high while monitored voltage is below the level, else low.
// - The reference turns on with the detector, without software help.
// - Sleep turns the detector off even when enabled.
// - Flag follows every comparator toggle; no filtering is applied.
// - Delayed request is one shared interrupt source; flag stays pollable.
// - Hardware raises the request only after a fixed delay from the flag rising; software may also preset it.
// - In idle and enabled, a low event sets the request and wakes unless the request is already set; in sleep the detector is off, so no wake.
`default_nettype none

package lvdet_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MASK = 8'h08;
   localparam logic [7:0] OFS_SET = 8'h0C;
   localparam logic [7:0] OFS_INFO = 8'h10;
   // Control register fields
   localparam int CTRL_W = 8;
   localparam int BIT_FLAG = 5;
   localparam int BIT_ON = 4;
   localparam int BIT_BGB = 3;
   localparam int THR_HI = 2;
   localparam int THR_LO = 0;
   localparam logic [2:0] THR_EXT_PIN = 3'h0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Status and mask fields
   localparam int IRQ_W = 2;
   localparam int ST_LOWVOLT = 0;
   localparam int ST_SETTLED = 1;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   // Info register fields
   localparam int INFO_SETTLED = 0;
   localparam int INFO_ACTIVE = 1;
   // Timing
   localparam int CLK_NS = 10;
   localparam int SETTLE_NS = 15000;
   localparam int IRQ_DELAY_NS = 60000;
   localparam int CNT_W = 16;
   localparam logic [15:0] SETTLE_CYC =
      16'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] IRQ_DELAY_CYC =
      16'((IRQ_DELAY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   // Sleep policy: 0 turns the detector off in sleep
   localparam logic SLEEP_KEEPS_DETECTOR = 1'b0;
endpackage

`default_nettype wire

// >>> lvdet_sync2.sv
// Two-stage synchroniser for the asynchronous comparator output.
// Assumes pclk and presetn of the main controller.
`default_nettype none

module lvdet_sync2 (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Data
   input wire logic d_async,
   output logic q
);
   logic meta_reg;

   // Only the second stage reads the first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= 1'b0;
         q <= 1'b0;
      end else if (ce) begin
         meta_reg <= d_async;
         q <= meta_reg;
      end
   end
endmodule

`default_nettype wire

// >>> lvdet_ctrl.sv
// Low-voltage detector controller: APB registers, analog control outputs,
// flag, settling and interrupt delay counters, interrupt and wake logic.
// Assumes an asynchronous comparator output and sleep/idle level inputs.
//
// Added by the designer: the APB slave port and the address map.
`default_nettype none

module lvdet_ctrl (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog side
   input wire logic comp_below_async,
   output logic detector_on,
   output logic reference_on,
   output logic bandgap_buffer_on,
   output logic [2:0] threshold_select,
   output logic external_sense_input,
   // Power state
   input wire logic sleep_mode,
   input wire logic idle_mode,
   // Interrupt and wake
   output logic irq,
   output logic wake_req
);
   logic [2:0] thr_reg;
   logic on_reg;
   logic bgb_reg;
   logic flag_reg;
   logic [1:0] status_reg;
   logic [1:0] status_next;
   logic [1:0] mask_reg;
   logic [15:0] settle_cnt_reg;
   logic settled_reg;
   logic [15:0] irq_cnt_reg;
   logic comp_sync;
   logic access;
   logic wr_take;
   logic irq_fire;
   logic settle_fire;
   logic active;
   logic [1:0] st_clr;
   logic [1:0] st_set;

   // Word select of the current request
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, lvdet_pkg::OFS_CTRL) || hit(a, lvdet_pkg::OFS_STATUS)
         || hit(a, lvdet_pkg::OFS_MASK) || hit(a, lvdet_pkg::OFS_SET)
         || hit(a, lvdet_pkg::OFS_INFO);
   endfunction

   lvdet_sync2 u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .d_async(comp_below_async),
      .q(comp_sync)
   );

   assign access = psel && penable && !pready;
   assign wr_take = psel && penable && pready && pwrite && !pslverr;

   // Sleep overrides the enable bit
   assign active = on_reg &&
      !(sleep_mode && !lvdet_pkg::SLEEP_KEEPS_DETECTOR);

   // APB handshake: answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= access;
         pslverr <= access && !mapped(paddr);
      end
   end

   // Read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (ce) begin
         prdata <= 32'h0000_0000;
         if (access && !pwrite) begin
            if (hit(paddr, lvdet_pkg::OFS_CTRL)) begin
               // Upper bits stay zero flag read only
               prdata[lvdet_pkg::BIT_FLAG] <= flag_reg;
               prdata[lvdet_pkg::BIT_ON] <= on_reg;
               prdata[lvdet_pkg::BIT_BGB] <= bgb_reg;
               prdata[lvdet_pkg::THR_HI:lvdet_pkg::THR_LO] <= thr_reg;
            end else if (hit(paddr, lvdet_pkg::OFS_STATUS)) begin
               prdata[1:0] <= status_reg;
            end else if (hit(paddr, lvdet_pkg::OFS_MASK)) begin
               prdata[1:0] <= mask_reg;
            end else if (hit(paddr, lvdet_pkg::OFS_INFO)) begin
               prdata[lvdet_pkg::INFO_SETTLED] <= settled_reg;
               prdata[lvdet_pkg::INFO_ACTIVE] <= active;
            end
         end
      end
   end

   // Control fields written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_reg <= lvdet_pkg::CTRL_RESET[lvdet_pkg::BIT_ON];
         bgb_reg <= lvdet_pkg::CTRL_RESET[lvdet_pkg::BIT_BGB];
         thr_reg <=
            lvdet_pkg::CTRL_RESET[lvdet_pkg::THR_HI:lvdet_pkg::THR_LO];
      end else if (ce && wr_take && hit(paddr, lvdet_pkg::OFS_CTRL)) begin
         on_reg <= pwdata[lvdet_pkg::BIT_ON];
         bgb_reg <= pwdata[lvdet_pkg::BIT_BGB];
         thr_reg <= pwdata[lvdet_pkg::THR_HI:lvdet_pkg::THR_LO];
      end
   end

   // Mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg <= lvdet_pkg::IRQ_RESET;
      end else if (ce && wr_take && hit(paddr, lvdet_pkg::OFS_MASK)) begin
         mask_reg <= pwdata[1:0];
      end
   end

   // Analog control outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         detector_on <= 1'b0;
         reference_on <= 1'b0;
         bandgap_buffer_on <= 1'b0;
         threshold_select <= lvdet_pkg::THR_EXT_PIN;
         external_sense_input <= 1'b1;
      end else if (ce) begin
         detector_on <= active;
         reference_on <= active;
         bandgap_buffer_on <= bgb_reg;
         threshold_select <= thr_reg;
         external_sense_input <= (thr_reg == lvdet_pkg::THR_EXT_PIN);
      end
   end

   // Flag tracks the synchronised comparator, no filter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_reg <= 1'b0;
      end else if (ce) begin
         flag_reg <= active && comp_sync;
      end
   end

   // Settling counter, restarted whenever the detector is off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_cnt_reg <= lvdet_pkg::CNT_ZERO;
         settled_reg <= 1'b0;
      end else if (ce) begin
         if (!active) begin
            settle_cnt_reg <= lvdet_pkg::CNT_ZERO;
            settled_reg <= 1'b0;
         end else if (settle_cnt_reg != lvdet_pkg::SETTLE_CYC) begin
            settle_cnt_reg <= settle_cnt_reg + lvdet_pkg::CNT_ONE;
            settled_reg <= settle_fire;
         end
      end
   end

   // Software reads the settled bit before trusting the flag
   assign settle_fire = active &&
      (settle_cnt_reg == lvdet_pkg::SETTLE_CYC - lvdet_pkg::CNT_ONE);

   // Interrupt delay counter, restarted on each flag rise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_cnt_reg <= lvdet_pkg::CNT_ZERO;
      end else if (ce) begin
         if (!flag_reg) begin
            irq_cnt_reg <= lvdet_pkg::CNT_ZERO;
         end else if (irq_cnt_reg != lvdet_pkg::IRQ_DELAY_CYC) begin
            irq_cnt_reg <= irq_cnt_reg + lvdet_pkg::CNT_ONE;
         end
      end
   end

   assign irq_fire = flag_reg &&
      (irq_cnt_reg == lvdet_pkg::IRQ_DELAY_CYC - lvdet_pkg::CNT_ONE);

   // Sticky status; set wins over clear; software may preset
   always_comb begin
      st_clr = 2'h0;
      st_set = 2'h0;
      if (wr_take && hit(paddr, lvdet_pkg::OFS_STATUS)) begin
         st_clr = pwdata[1:0];
      end
      if (wr_take && hit(paddr, lvdet_pkg::OFS_SET)) begin
         st_set = pwdata[1:0];
      end
      st_set[lvdet_pkg::ST_LOWVOLT] = st_set[lvdet_pkg::ST_LOWVOLT] ||
         irq_fire;
      st_set[lvdet_pkg::ST_SETTLED] = st_set[lvdet_pkg::ST_SETTLED] ||
         settle_fire;
      status_next = (status_reg & ~st_clr) | st_set;
   end

   // Stale requests are cleared by software before unmasking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= lvdet_pkg::IRQ_RESET;
      end else if (ce) begin
         status_reg <= status_next;
      end
   end

   // Shared interrupt output and wake request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
         wake_req <= 1'b0;
      end else if (ce) begin
         irq <= |(status_next & mask_reg);
         wake_req <= (sleep_mode || idle_mode) && irq_fire &&
            !status_reg[lvdet_pkg::ST_LOWVOLT];
      end
   end

   property p_reserved_zero;
      @(posedge pclk) disable iff (!presetn || !ce)
      (access && !pwrite && hit(paddr, lvdet_pkg::OFS_CTRL))
         |=> prdata[7:6] == 2'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved control bits read nonzero");

   property p_flag_read;
      @(posedge pclk) disable iff (!presetn || !ce)
      (access && !pwrite && hit(paddr, lvdet_pkg::OFS_CTRL))
         |=> prdata[lvdet_pkg::BIT_FLAG] == $past(flag_reg);
   endproperty
   a_flag_read: assert property (p_flag_read)
      else $error("flag read does not match flag");

   property p_on_follows;
      @(posedge pclk) disable iff (!presetn || !ce)
      (wr_take && hit(paddr, lvdet_pkg::OFS_CTRL) && !sleep_mode)
         ##1 (ce && !sleep_mode)
         |=> detector_on == $past(pwdata[lvdet_pkg::BIT_ON], 2);
   endproperty
   a_on_follows: assert property (p_on_follows)
      else $error("detector enable not applied");

   property p_bgb;
      @(posedge pclk) disable iff (!presetn || !ce)
      ##1 bandgap_buffer_on == $past(bgb_reg);
   endproperty
   a_bgb: assert property (p_bgb)
      else $error("bandgap buffer output mismatch");

   property p_ext_sel;
      @(posedge pclk) disable iff (!presetn || !ce)
      external_sense_input == (threshold_select == lvdet_pkg::THR_EXT_PIN);
   endproperty
   a_ext_sel: assert property (p_ext_sel)
      else $error("sense source does not match code");

   property p_flag_low_off;
      @(posedge pclk) disable iff (!presetn || !ce)
      !active |=> !flag_reg;
   endproperty
   a_flag_low_off: assert property (p_flag_low_off)
      else $error("flag high while detector off");

   property p_ref_auto;
      @(posedge pclk) disable iff (!presetn || !ce)
      ##1 reference_on == detector_on;
   endproperty
   a_ref_auto: assert property (p_ref_auto)
      else $error("reference not tied to detector");

   property p_sleep_off;
      @(posedge pclk) disable iff (!presetn || !ce)
      sleep_mode |=> !detector_on;
   endproperty
   a_sleep_off: assert property (p_sleep_off)
      else $error("detector on during sleep");

   property p_sync_path;
      @(posedge pclk) disable iff (!presetn || !ce)
      (active && comp_sync) |=> flag_reg;
   endproperty
   a_sync_path: assert property (p_sync_path)
      else $error("flag missed synchronised input");

   property p_irq_delay;
      @(posedge pclk) disable iff (!presetn || !ce)
      ($rose(status_reg[lvdet_pkg::ST_LOWVOLT]) && !$past(wr_take))
         |-> $past(flag_reg)
         && ($past(irq_cnt_reg) == lvdet_pkg::IRQ_DELAY_CYC - 16'h0001);
   endproperty
   a_irq_delay: assert property (p_irq_delay)
      else $error("request not raised after delay");

   property p_cnt_restart;
      @(posedge pclk) disable iff (!presetn || !ce)
      $rose(flag_reg) |-> irq_cnt_reg == 16'h0000;
   endproperty
   a_cnt_restart: assert property (p_cnt_restart)
      else $error("delay counter not restarted");

   property p_irq_out;
      @(posedge pclk) disable iff (!presetn || !ce)
      ##1 irq == |(status_reg & $past(mask_reg));
   endproperty
   a_irq_out: assert property (p_irq_out)
      else $error("interrupt output mismatch");

   property p_wake;
      @(posedge pclk) disable iff (!presetn || !ce)
      (irq_fire && idle_mode && !status_reg[lvdet_pkg::ST_LOWVOLT])
         |=> wake_req ##1 (!ce || !wake_req);
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake pulse wrong");
endmodule

`default_nettype wire

// >>> lvdet_analog_model.sv
// Behavioural comparator and reference of the low-voltage detector.
// Assumes the controller's analog-side outputs and voltages in millivolts.
`default_nettype none

module lvdet_analog_model (
   // Controls from the controller
   input wire logic detector_on,
   input wire logic reference_on,
   input wire logic [2:0] threshold_select,
   input wire logic external_sense_input,
   // Voltages in millivolts
   input var int supply_mv,
   input var int pin_mv,
   // Comparator output
   output logic comp_below_async
);
   timeunit 1ns;
   timeprecision 1ps;

   // Levels of codes 0 to 7 in millivolts
   int level_mv [8] = '{1040, 2200, 2400, 2700, 3000, 3300, 3600, 4000};
   int seen_mv;
   logic below;

   // Pin in pin mode, supply otherwise
   assign seen_mv = external_sense_input ? pin_mv : supply_mv;
   // Compares only while both detector and reference are powered
   assign below = detector_on && reference_on &&
      (seen_mv < level_mv[threshold_select]);

   // Output settles a few ns after its cause, unrelated to pclk
   always @(below) begin
      comp_below_async <= #3 below;
   end
endmodule

`default_nettype wire

// >>> lvdet_ctrl_tb.sv
// Self-checking bench of the low-voltage detector controller.
// Assumes the APB slave answers after one wait state and the analog model.
`default_nettype none

module lvdet_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic sleep_mode = 0, idle_mode = 0, ce = 1, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic pready, pslverr, comp, det_on, ref_on, bgb_on, ext_in, irq, wake_req;
   logic [2:0] thr;
   int supply_mv = 5000, pin_mv = 2000, n_wake = 0, n_errors = 0;
   int compares = 0, i, c, lo;
   int mv [8] = '{1040, 2200, 2400, 2700, 3000, 3300, 3600, 4000};

   lvdet_ctrl u_lvdet_ctrl (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .comp_below_async(comp), .detector_on(det_on),
      .reference_on(ref_on), .bandgap_buffer_on(bgb_on),
      .threshold_select(thr), .external_sense_input(ext_in),
      .sleep_mode(sleep_mode), .idle_mode(idle_mode), .irq(irq),
      .wake_req(wake_req));

   lvdet_analog_model u_lvdet_analog_model (.detector_on(det_on),
      .reference_on(ref_on), .threshold_select(thr),
      .external_sense_input(ext_in), .supply_mv(supply_mv),
      .pin_mv(pin_mv), .comp_below_async(comp));

   always #5 pclk = ~pclk;

   always @(posedge pclk) begin
      if (wake_req === 1'b1) n_wake <= n_wake + 1;
   end

   task final_report;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // One APB transfer; read data and error taken at the ready edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         n_errors++;
         $display("BAD t=%0t no ready", $time);
         final_report;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   initial begin
      cyc(10);
      presetn <= 1'b1;
      chk({det_on, ref_on, bgb_on, thr, ext_in}, 32'h00000001);
      apb(0, lvdet_pkg::OFS_CTRL, 32'h0);
      chk(rd, 32'h00000000);
      apb(0, lvdet_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h00000000);
      apb(0, lvdet_pkg::OFS_MASK, 32'h0);
      chk(rd, 32'h00000000);
      apb(0, 8'h40, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      apb(1, lvdet_pkg::OFS_CTRL, 32'hFFFFFFFF);
      apb(0, lvdet_pkg::OFS_CTRL, 32'h0);
      chk(rd, 32'h0000001F);
      chk({det_on, ref_on, bgb_on, thr, ext_in}, 32'h7E);
      // Clock enable low freezes the detector through a sleep pulse
      ce <= 1'b0;
      cyc(1);
      sleep_mode <= 1'b1;
      cyc(5);
      chk(det_on, 1'b1);
      sleep_mode <= 1'b0;
      cyc(2);
      ce <= 1'b1;
      cyc(1);
      chk(det_on, 1'b1);
      // Settled bit polled before the flag is trusted
      apb(0, lvdet_pkg::OFS_INFO, 32'h0);
      chk(rd, 32'h00000002);
      for (i = 0; i < 500 && rd[lvdet_pkg::INFO_SETTLED] !== 1'b1; i++) begin
         apb(0, lvdet_pkg::OFS_INFO, 32'h0);
      end
      chk(rd, 32'h00000003);
      apb(0, lvdet_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h00000002);
      // Every threshold code, just below and just above its level
      for (c = 0; c < 8; c++) begin
         apb(1, lvdet_pkg::OFS_CTRL, 32'h10 | c);
         for (lo = 1; lo >= 0; lo--) begin
            if (c == 0) begin
               pin_mv <= lo ? mv[0] - 50 : mv[0] + 50;
               supply_mv <= lo ? 5000 : 1000;
            end else begin
               supply_mv <= lo ? mv[c] - 50 : mv[c] + 50;
               pin_mv <= lo ? 2000 : 500;
            end
            cyc(8);
            apb(0, lvdet_pkg::OFS_CTRL, 32'h0);
            chk(rd, 32'h10 | c | (lo << 5));
            chk(ext_in, c == 0);
         end
      end
      apb(1, lvdet_pkg::OFS_CTRL, 32'h17);
      supply_mv <= 1000;
      sleep_mode <= 1'b1;
      cyc(8);
      chk({det_on, ref_on}, 32'h0);
      apb(0, lvdet_pkg::OFS_CTRL, 32'h0);
      chk(rd, 32'h00000017);
      sleep_mode <= 1'b0;
      supply_mv <= 5000;
      // Delayed request, restarted by a short recovery
      apb(1, lvdet_pkg::OFS_STATUS, 32'h3);
      apb(1, lvdet_pkg::OFS_MASK, 32'h1);
      chk(irq, 1'b0);
      supply_mv <= 1000;
      cyc(3000);
      supply_mv <= 5000;
      cyc(10);
      supply_mv <= 1000;
      cyc(5990);
      chk(irq, 1'b0);
      for (i = 0; i < 40 && irq !== 1'b1; i++) @(posedge pclk);
      chk(irq, 1'b1);
      apb(0, lvdet_pkg::OFS_CTRL, 32'h0);
      chk(rd, 32'h00000037);
      supply_mv <= 5000;
      cyc(8);
      apb(1, lvdet_pkg::OFS_STATUS, 32'h3);
      cyc(2);
      chk(irq, 1'b0);
      apb(1, lvdet_pkg::OFS_SET, 32'h1);
      cyc(2);
      chk(irq, 1'b1);
      apb(1, lvdet_pkg::OFS_MASK, 32'h0);
      cyc(2);
      chk(irq, 1'b0);
      chk(32'(n_wake), 32'h0);
      // Wake from idle, then wake suppressed by a preset request
      apb(1, lvdet_pkg::OFS_STATUS, 32'h3);
      idle_mode <= 1'b1;
      supply_mv <= 1000;
      cyc(6040);
      chk(32'(n_wake), 32'h1);
      supply_mv <= 5000;
      cyc(8);
      apb(1, lvdet_pkg::OFS_STATUS, 32'h3);
      apb(1, lvdet_pkg::OFS_SET, 32'h1);
      supply_mv <= 1000;
      cyc(6040);
      chk(32'(n_wake), 32'h1);
      final_report;
   end
endmodule

`default_nettype wire
